/* core/nvpw_dev.sv */
// data nvm access: column latches, page program sequencer, xram routing
`timescale 1ns/1ns
module nvpw_dev #(
	parameter int PROG_CNT = nvpw_pkg::PROG_CYCLES
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	nvpw_if.dev bus
);
	import nvpw_pkg::*;

	// =====================================================
	// usage notes
	// reads of the nvm window while busy return 8'hff, not stale data
	// latch loads and launch commands are dropped while busy, silently
	// software should poll the busy flag before any load or read
	// an idle cycle between 5x and ax keeps the arm; a move, a control
	// write other than 5x or a flagged instruction breaks the pair
	// every accepted load overwrites the row, so a stray page loaded last in a
	// batch moves the whole batch to that page
	// latches keep their bytes after programming; only the valid bits
	// are cleared, so stale bytes never reach a later row
	// cells are held per column so that each cell has a single writer
	// xram is 256 bytes and aliases every block outside the enabled
	// nvm window
	// the cmd field reads back the last nibble written, refused or not
	// reserved control bits read as zero
	// the program timer runs PROG_CNT cycles; the default is long, so
	// simulation passes a short count

	// =====================================================
	// storage
	// nvm cells live per column below; this is the column read mux
	logic [7:0] col_rd [PAGE_BYTES];
	logic [7:0] xram_mem [XRAM_BYTES];
	logic [7:0] latch_mem [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] valid_reg;
	logic [PAGE_W-1:0] row_reg;
	logic [3:0] cmd_reg;
	logic space_en_reg;
	logic busy_reg;
	logic armed_reg;
	logic [31:0] prog_cnt_reg;
	logic [7:0] rdata_reg;
	logic rvalid_reg;

	// =====================================================
	// decode
	logic in_nvm;
	logic [PAGE_W-1:0] adr_page;
	logic [COL_W-1:0] adr_col;
	logic latch_wr;
	logic prog_done;
	assign in_nvm = space_en_reg && (bus.data_pointer <= NVM_LAST);
	assign adr_page = bus.data_pointer[NVM_ADDR_W-1:COL_W];
	assign adr_col = bus.data_pointer[COL_W-1:0];
	// busy masks loads here once, not in every column
	// no latch loads while busy
	assign latch_wr = (bus.op == NVPW_OP_XWR) && in_nvm && !busy_reg;
	assign prog_done = busy_reg && (prog_cnt_reg == 32'(PROG_CNT - 1));

	// control register and launch sequencing
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			space_en_reg <= 1'b0;
			cmd_reg <= 4'h0;
			armed_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			if (bus.op == NVPW_OP_CWR) begin
				// busy bit of the write is dropped
				space_en_reg <= bus.wdata[SPACE_EN_BIT];
				cmd_reg <= bus.wdata[CMD_MSB:CMD_LSB];
				// arm on 5x, launch on Ax
				if (!busy_reg && armed_reg && bus.wdata[CMD_MSB:CMD_LSB] == CMD_LAUNCH) begin
					busy_reg <= 1'b1;
					armed_reg <= 1'b0;
				end else begin
					armed_reg <= !busy_reg && (bus.wdata[CMD_MSB:CMD_LSB] == CMD_ARM);
				end
			end else if (bus.instr_i) begin
				armed_reg <= 1'b0;
			end
			// done needs busy already set, so it never meets a launch
			// clear when row done
			if (prog_done) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// program cycle timer
	// restarts from zero on the clear edge, ready for the next launch
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			prog_cnt_reg <= 32'h0;
		end else if (busy_reg && !prog_done) begin
			prog_cnt_reg <= prog_cnt_reg + 32'h1;
		end else begin
			prog_cnt_reg <= 32'h0;
		end
	end

	// column latches and row transfer, one per byte
	genvar gi;
	generate
		for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_col
			// one cell per page in this column
			logic [7:0] col_mem [NVM_BYTES / PAGE_BYTES];
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					valid_reg[gi] <= 1'b0;
				end else if (latch_wr && adr_col == COL_W'(gi)) begin
					valid_reg[gi] <= 1'b1;
				end else if (prog_done) begin
					valid_reg[gi] <= 1'b0;
				end
			end
			always_ff @(posedge clk_i) begin
				if (latch_wr && adr_col == COL_W'(gi)) begin
					latch_mem[gi] <= bus.wdata;
				end
			end
			always_ff @(posedge clk_i) begin
				if (prog_done && valid_reg[gi]) begin
					col_mem[row_reg] <= latch_mem[gi];
				end
			end
			// page picks the cell of this column
			assign col_rd[gi] = col_mem[adr_page];
		end
	endgenerate

	// only accepted loads move the row, so a refused load while busy
	// cannot retarget the row being programmed
	// last loaded page wins
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			row_reg <= '0;
		end else if (latch_wr) begin
			row_reg <= adr_page;
		end
	end

	// no reset: ram contents are undefined until written
	// xram when space disabled or outside nvm
	always_ff @(posedge clk_i) begin
		if (bus.op == NVPW_OP_XWR && !in_nvm) begin
			xram_mem[bus.data_pointer[7:0]] <= bus.wdata;
		end
	end

	// read path, answer one cycle later; busy nvm reads give 8'hff
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= (bus.op == NVPW_OP_XRD);
			if (bus.op == NVPW_OP_XRD) begin
				if (in_nvm) begin
					rdata_reg <= busy_reg ? 8'hff : col_rd[adr_col];
				end else begin
					rdata_reg <= xram_mem[bus.data_pointer[7:0]];
				end
			end
		end
	end

	// every bus output comes straight from a register
	assign bus.rdata = rdata_reg;
	assign bus.rvalid = rvalid_reg;
	// reserved bits 3:2 read as zero
	assign bus.nvm_control_register = {cmd_reg, 2'b00, space_en_reg, busy_reg};
endmodule // nvpw_dev

/* core/nvpw_pkg.sv */
// shared constants and types for the data nvm page-write access block
package nvpw_pkg;
	// =====================================================
	// address map and geometry
	localparam int ADDR_W = 16;
	localparam int NVM_ADDR_W = 11;
	localparam int PAGE_W = 4;
	localparam int COL_W = 7;
	localparam int PAGE_BYTES = 128;
	localparam int NVM_BYTES = 2048;
	localparam int XRAM_BYTES = 256;
	localparam logic [15:0] NVM_BASE = 16'h0000;
	localparam logic [15:0] NVM_LAST = 16'h07ff;
	// =====================================================
	// control register layout
	localparam int CMD_MSB = 7;
	localparam int CMD_LSB = 4;
	localparam int SPACE_EN_BIT = 1;
	localparam int BUSY_BIT = 0;
	localparam logic [3:0] CMD_ARM = 4'h5;
	localparam logic [3:0] CMD_LAUNCH = 4'ha;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// =====================================================
	// program timing: 4 ms at 20 MHz, long so made a parameter default
	localparam int CLK_HZ = 20000000;
	localparam int PROG_TIME_US = 4000;
	localparam int PROG_CYCLES = (PROG_TIME_US * (CLK_HZ / 1000000));
	// =====================================================
	// core side access kinds
	typedef enum logic [1:0] {
		NVPW_OP_NONE = 2'b00,
		NVPW_OP_XRD = 2'b01,
		NVPW_OP_XWR = 2'b10,
		NVPW_OP_CWR = 2'b11
	} nvpw_op_t;
endpackage

/* core/nvpw_if.sv */
// bus between the cpu-side sequencer and the nvm access block
`timescale 1ns/1ns
interface nvpw_if;
	import nvpw_pkg::*;
	logic instr_i;
	nvpw_op_t op;
	logic [15:0] data_pointer;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;
	logic [7:0] nvm_control_register;
	modport dev (input instr_i, input op, input data_pointer, input wdata,
		output rdata, output rvalid, output nvm_control_register);
	modport cpu (output instr_i, output op, output data_pointer, output wdata,
		input rdata, input rvalid, input nvm_control_register);
endinterface // nvpw_if

/* core/nvpw_cpu.sv */
// cpu-side sequencer: turns user requests into data-space moves
`timescale 1ns/1ns
module nvpw_cpu (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic req_i,
	input wire nvpw_pkg::nvpw_op_t req_op_i,
	input wire logic [15:0] req_addr_i,
	input wire logic [7:0] req_data_i,
	input wire logic other_instr_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic busy_o,
	nvpw_if.cpu bus
);
	import nvpw_pkg::*;

	// =====================================================
	// one request per cycle drives one move
	nvpw_op_t op_reg;
	logic [15:0] ptr_reg;
	logic [7:0] wdata_reg;
	logic instr_reg;
	logic [7:0] rd_reg;
	logic rv_reg;
	logic busy_reg;

	// caller keeps ints off, sequences moves
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			op_reg <= NVPW_OP_NONE;
			ptr_reg <= 16'h0000;
			wdata_reg <= 8'h00;
			instr_reg <= 1'b0;
		end else begin
			op_reg <= req_i ? req_op_i : NVPW_OP_NONE;
			ptr_reg <= req_addr_i;
			wdata_reg <= req_data_i;
			instr_reg <= req_i || other_instr_i;
		end
	end

	// answers and status mirror
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rd_reg <= 8'h00;
			rv_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			rd_reg <= bus.rdata;
			rv_reg <= bus.rvalid;
			busy_reg <= bus.nvm_control_register[BUSY_BIT];
		end
	end

	assign bus.op = op_reg;
	assign bus.data_pointer = ptr_reg;
	assign bus.wdata = wdata_reg;
	assign bus.instr_i = instr_reg;
	assign rd_data_o = rd_reg;
	assign rd_valid_o = rv_reg;
	assign busy_o = busy_reg;
endmodule // nvpw_cpu

/* testbench/nvpw_asserts.sv */
// checker on the bus between the cpu end and the nvm device end
`timescale 1ns/1ns
module nvpw_asserts (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic instr_i,
	input wire nvpw_pkg::nvpw_op_t op,
	input wire logic [15:0] data_pointer,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic [7:0] nvm_control_register
);
	import nvpw_pkg::*;
	// ====================
	// bus properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// busy flag and an nvm read on the bus
	wire logic busy = nvm_control_register[0];
	wire logic cw = instr_i && op == NVPW_OP_CWR;
	wire logic nvm_rd = instr_i && op == NVPW_OP_XRD && nvm_control_register[1]
		&& data_pointer <= NVM_LAST;
	AST_RESET_CLEAR: assert property (
		$rose(nrst_i) |-> nvm_control_register == CTRL_RESET) else $error("reset value");
	AST_RVALID_CAUSE: assert property (
		rvalid |-> $past(instr_i) && $past(op) == NVPW_OP_XRD) else $error("stray rvalid");
	AST_BUSY_READ: assert property (
		nvm_rd && busy |=> rdata == 8'hff) else $error("read while busy");
	AST_LAUNCH_CMD: assert property (
		$rose(busy) |-> $past(op) == NVPW_OP_CWR && $past(wdata[7:4]) == CMD_LAUNCH)
		else $error("busy without launch");
	AST_ARM_BEFORE: assert property (
		$rose(busy) |-> $past(op, 2) == NVPW_OP_CWR && $past(wdata[7:4], 2) == CMD_ARM)
		else $error("busy without arm");
	AST_BUSY_SPAN: assert property (
		$rose(busy) |-> busy[*8] ##[1:30] !busy) else $error("busy span");
	AST_BUSY_HOLD: assert property (
		cw && busy |=> busy) else $error("busy cleared by write");
	AST_SPACE_EN: assert property (
		cw && !busy |=> nvm_control_register[1] == $past(wdata[1])) else $error("space bit");
	cover property ($rose(busy));
	cover property (nvm_rd && busy);
	cover property ($fell(busy));
endmodule // nvpw_asserts

/* testbench/tb_top.sv */
// self-checking bench for the cpu and nvm device ends
`timescale 1ns/1ns
module tb_top;
	import nvpw_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic req_i = 1'b0;
	nvpw_op_t req_op_i = NVPW_OP_NONE;
	logic [15:0] req_addr_i = 16'h0000;
	logic [7:0] req_data_i = 8'h00;
	logic other_instr_i = 1'b0;
	logic [7:0] rd_data_o;
	logic rd_valid_o;
	logic busy_o;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	nvpw_if bus_if();
	// short program time keeps the run brief
	nvpw_dev #(.PROG_CNT(20)) nvpw_dev_inst (.clk_i, .nrst_i, .bus(bus_if));
	nvpw_cpu nvpw_cpu_inst (.clk_i, .nrst_i, .req_i, .req_op_i, .req_addr_i, .req_data_i,
		.other_instr_i, .rd_data_o, .rd_valid_o, .busy_o, .bus(bus_if));
	nvpw_asserts nvpw_asserts_inst (.clk_i, .nrst_i, .instr_i(bus_if.instr_i), .op(bus_if.op),
		.data_pointer(bus_if.data_pointer), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
		.rvalid(bus_if.rvalid), .nvm_control_register(bus_if.nvm_control_register));
	// 50 ns clock and hang guard
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one move per edge; idle drops the request
	task automatic mv(input nvpw_op_t o, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_i <= 1'b1;
		other_instr_i <= 1'b0;
		req_op_i <= o;
		req_addr_i <= a;
		req_data_i <= d;
	endtask
	task automatic idle();
		@(posedge clk_i);
		req_i <= 1'b0;
		other_instr_i <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		mv(NVPW_OP_XRD, a, 8'h00);
		idle();
		repeat (6) begin
			@(negedge clk_i);
			if (rd_valid_o === 1'b1) break;
		end
		chk({rd_valid_o, rd_data_o}, {1'b1, e});
	endtask
	// launch, poke the device while busy, then wait out the row
	task automatic prog();
		mv(NVPW_OP_CWR, 16'h0000, 8'h52);
		mv(NVPW_OP_CWR, 16'h0000, 8'ha2);
		idle();
		repeat (5) @(negedge clk_i);
		chk({8'h00, busy_o}, 9'h001);
		rd(16'h0205, 8'hff);
		mv(NVPW_OP_XWR, 16'h0205, 8'h99);
		mv(NVPW_OP_CWR, 16'h0000, 8'h02);
		idle();
		repeat (60) begin
			@(negedge clk_i);
			if (busy_o === 1'b0) break;
		end
		chk({8'h00, busy_o}, 9'h000);
	endtask
	task automatic t_xram();
		@(negedge clk_i);
		chk({1'b0, bus_if.nvm_control_register}, {1'b0, CTRL_RESET});
		mv(NVPW_OP_XWR, 16'h0010, 8'h3c);
		idle();
		rd(16'h0010, 8'h3c);
		$display("t_xram done");
	endtask
	task automatic t_prog();
		mv(NVPW_OP_CWR, 16'h0000, 8'h02);
		mv(NVPW_OP_XWR, 16'h0205, 8'h77);
		idle();
		prog();
		rd(16'h0205, 8'h77);
		$display("t_prog done");
	endtask
	task automatic t_page();
		mv(NVPW_OP_XWR, 16'h0105, 8'h11);
		mv(NVPW_OP_XWR, 16'h0086, 8'h22);
		idle();
		prog();
		rd(16'h0085, 8'h11);
		rd(16'h0086, 8'h22);
		mv(NVPW_OP_XWR, 16'h0207, 8'h33);
		idle();
		prog();
		rd(16'h0207, 8'h33);
		rd(16'h0205, 8'h77);
		mv(NVPW_OP_CWR, 16'h0000, 8'h00);
		mv(NVPW_OP_XWR, 16'h0205, 8'hc3);
		idle();
		rd(16'h0205, 8'hc3);
		mv(NVPW_OP_CWR, 16'h0000, 8'h02);
		idle();
		rd(16'h0205, 8'h77);
		// first and last column of the top page, then just past the window
		mv(NVPW_OP_XWR, 16'h0780, 8'h5a);
		mv(NVPW_OP_XWR, 16'h07ff, 8'ha5);
		idle();
		prog();
		rd(16'h0780, 8'h5a);
		rd(16'h07ff, 8'ha5);
		mv(NVPW_OP_XWR, 16'h0800, 8'he1);
		idle();
		rd(16'h0800, 8'he1);
		$display("t_page done");
	endtask
	// an instruction or another write between the commands must abort
	task automatic t_abort();
		mv(NVPW_OP_XWR, 16'h0300, 8'h44);
		mv(NVPW_OP_CWR, 16'h0000, 8'h52);
		@(posedge clk_i);
		req_i <= 1'b0;
		other_instr_i <= 1'b1;
		mv(NVPW_OP_CWR, 16'h0000, 8'ha2);
		idle();
		repeat (5) @(negedge clk_i);
		chk({8'h00, busy_o}, 9'h000);
		mv(NVPW_OP_CWR, 16'h0000, 8'h52);
		mv(NVPW_OP_CWR, 16'h0000, 8'h02);
		mv(NVPW_OP_CWR, 16'h0000, 8'ha2);
		idle();
		repeat (5) @(negedge clk_i);
		chk({8'h00, busy_o}, 9'h000);
		$display("t_abort done");
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_xram();
		t_prog();
		t_page();
		t_abort();
		final_report();
	end
endmodule // tb_top
